// ==== verilog/parallel_io_pkg.sv ====
package parallel_io_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // register addresses inside the special-function space
  localparam logic [5:0] SFR_FIRST = 6'h00;
  localparam logic [5:0] SFR_LAST = 6'h3F;
  localparam logic [5:0] PORT0_OUTPUT_LATCH_ADDR = 6'h00;
  localparam logic [5:0] PORT1_OUTPUT_LATCH_ADDR = 6'h01;
  localparam logic [5:0] PORT2_OUTPUT_LATCH_ADDR = 6'h02;
  localparam logic [5:0] PORT3_OUTPUT_LATCH_ADDR = 6'h03;
  localparam logic [5:0] PORT4_OUTPUT_LATCH_ADDR = 6'h04;
  localparam logic [5:0] PORT0_PIN_INPUT_ADDR = 6'h08;
  localparam logic [5:0] PORT2_PIN_INPUT_ADDR = 6'h0A;
  localparam logic [5:0] PORT1_DIRECTION_ADDR = 6'h0D;
  localparam logic [5:0] PORT3_DIRECTION_ADDR = 6'h0E;
  localparam logic [5:0] PORT4_DIRECTION_ADDR = 6'h0F;

  // port widths
  localparam int PORT0_W = 8;
  localparam int PORT1_W = 6;
  localparam int PORT2_W = 3;
  localparam int PORT3_W = 8;
  localparam int PORT4_W = 8;

  // field positions
  localparam int PORT_ZERO_BIT_ZERO = 0;
  localparam int PORT_TWO_FIRST_PIN = 0;
  localparam int LOW_CRYSTAL_INPUT = 1;
  localparam int LOW_CRYSTAL_OUTPUT = 2;
  localparam int ANALOG_SEL_W = 3;

  // reset values
  localparam logic [7:0] PORT0_LATCH_RST = 8'hFF;
  localparam logic [5:0] PORT1_LATCH_RST = 6'h00;
  localparam logic [5:0] PORT1_DIR_RST = 6'h00;
  localparam logic [2:0] PORT2_LATCH_RST = 3'h7;
  localparam logic [7:0] PORT3_LATCH_RST = 8'h00;
  localparam logic [7:0] PORT3_DIR_RST = 8'h00;
  localparam logic [7:0] PORT4_LATCH_RST = 8'h00;
  localparam logic [7:0] PORT4_DIR_RST = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [1:0] SYNC_RST = 2'h0;

  // one CPU access to the special-function space
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sfr_req_t;

  // secondary-function controls owned by neighbouring blocks
  typedef struct packed {
    logic interrupt_pin_select;
    logic dual_clock_mode;
    logic analog_input_disable;
    logic [ANALOG_SEL_W-1:0] analog_channel_select;
  } alt_ctrl_t;

endpackage

// ==== verilog/five_port_parallel_io.sv ====
`timescale 1ns/1ps
// Operation
// - port registers live in the 64-byte special-function space, plain reads and writes.
// - inputs have no latch; pins are taken at read time.
// - pin levels are sampled in the first state of the read cycle.
// - pin output changes in the second state of the write cycle.
// - port zero latches reset to one; one means input, zero drives low.
// - port zero latch and pin levels have separate read addresses.
// - port zero bit zero resets as input; select bit picks interrupt use.
// - port one bits are input at direction zero, output at one.
// - reset clears port one direction and latches.
// - latches of ports one, three, four accept writes in any direction.
// - upper two bits of port one data and direction read undefined; here they read zero.
// - ports one, three, four read pins for inputs, latches for outputs.
// - port two latches reset to one.
// - port two second and third pins serve the crystal in dual-clock mode.
// - falling edge on port two first pin sets its interrupt even as output.
// - port two has separate latch and pin reads; upper five bits unstable; here they read zero.
// - reset clears port three direction; analog disable starts at one.
// - with analog enabled, the selected port three pin is analog only.
// - selected analog pin reads zero; other pins read their level.
// - port four has per-bit direction; direction and latches reset to zero.
// - with select bit zero, port zero bit zero edges set no interrupt.
module five_port_parallel_io
  import parallel_io_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire sfr_req_t req_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic hit_o,
  input wire alt_ctrl_t alt_i,
  input wire logic [PORT0_W-1:0] port0_pin_i,
  output logic [PORT0_W-1:0] port0_pin_o,
  output logic [PORT0_W-1:0] port0_pin_oe_o,
  input wire logic [PORT1_W-1:0] port1_pin_i,
  output logic [PORT1_W-1:0] port1_pin_o,
  output logic [PORT1_W-1:0] port1_pin_oe_o,
  input wire logic [PORT2_W-1:0] port2_pin_i,
  output logic [PORT2_W-1:0] port2_pin_o,
  output logic [PORT2_W-1:0] port2_pin_oe_o,
  input wire logic [PORT3_W-1:0] port3_pin_i,
  output logic [PORT3_W-1:0] port3_pin_o,
  output logic [PORT3_W-1:0] port3_pin_oe_o,
  input wire logic [PORT4_W-1:0] port4_pin_i,
  output logic [PORT4_W-1:0] port4_pin_o,
  output logic [PORT4_W-1:0] port4_pin_oe_o,
  output logic [PORT3_W-1:0] analog_pin_select_o,
  output logic ext_irq_zero_set_o,
  output logic port_two_irq_set_o
);

  // per-bit readback: pins for inputs, latch for outputs
  function automatic logic [7:0] mixed_read(input logic [7:0] pins, input logic [7:0] latch,
                                            input logic [7:0] dir);
    mixed_read = (pins & ~dir) | (latch & dir);
  endfunction

  // one-hot decode of the analog channel field
  function automatic logic [PORT3_W-1:0] channel_onehot(input logic [ANALOG_SEL_W-1:0] sel);
    channel_onehot = '0;
    channel_onehot[sel] = 1'b1;
  endfunction

  logic [PORT0_W-1:0] port0_latch_r;
  logic [PORT1_W-1:0] port1_latch_r;
  logic [PORT1_W-1:0] port1_dir_r;
  logic [PORT2_W-1:0] port2_latch_r;
  logic [PORT3_W-1:0] port3_latch_r;
  logic [PORT3_W-1:0] port3_dir_r;
  logic [PORT4_W-1:0] port4_latch_r;
  logic [PORT4_W-1:0] port4_dir_r;

  logic [PORT0_W-1:0] port0_meta_r;
  logic [PORT0_W-1:0] port0_sync_r;
  logic [PORT1_W-1:0] port1_meta_r;
  logic [PORT1_W-1:0] port1_sync_r;
  logic [PORT2_W-1:0] port2_meta_r;
  logic [PORT2_W-1:0] port2_sync_r;
  logic [PORT3_W-1:0] port3_meta_r;
  logic [PORT3_W-1:0] port3_sync_r;
  logic [PORT4_W-1:0] port4_meta_r;
  logic [PORT4_W-1:0] port4_sync_r;

  logic p00_prev_r;
  logic p20_prev_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic ext_irq_zero_r;
  logic port_two_irq_r;

  logic wr_p0;
  logic wr_p1;
  logic wr_p2;
  logic wr_p3;
  logic wr_p4;
  logic wr_d1;
  logic wr_d3;
  logic wr_d4;
  logic [PORT3_W-1:0] analog_sel;
  logic [PORT3_W-1:0] port3_digital;
  logic [PORT2_W-1:0] port2_crystal;

  // write strobes; the whole 6-bit space belongs to the special-function map
  assign wr_p0 = req_i.wr && (req_i.addr == PORT0_OUTPUT_LATCH_ADDR);
  assign wr_p1 = req_i.wr && (req_i.addr == PORT1_OUTPUT_LATCH_ADDR);
  assign wr_p2 = req_i.wr && (req_i.addr == PORT2_OUTPUT_LATCH_ADDR);
  assign wr_p3 = req_i.wr && (req_i.addr == PORT3_OUTPUT_LATCH_ADDR);
  assign wr_p4 = req_i.wr && (req_i.addr == PORT4_OUTPUT_LATCH_ADDR);
  assign wr_d1 = req_i.wr && (req_i.addr == PORT1_DIRECTION_ADDR);
  assign wr_d3 = req_i.wr && (req_i.addr == PORT3_DIRECTION_ADDR);
  assign wr_d4 = req_i.wr && (req_i.addr == PORT4_DIRECTION_ADDR);

  // analog channel takes the pin away from the digital driver
  assign analog_sel = alt_i.analog_input_disable ? '0 : channel_onehot(alt_i.analog_channel_select);
  assign port3_digital = ~analog_sel;
  assign port2_crystal = alt_i.dual_clock_mode ?
                         (PORT2_W'(1) << LOW_CRYSTAL_INPUT) | (PORT2_W'(1) << LOW_CRYSTAL_OUTPUT) : '0;

  // port zero output latch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port0_latch_r <= PORT0_LATCH_RST;
    end else if (wr_p0) begin
      port0_latch_r <= req_i.wdata;
    end
  end

  // port one output latch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port1_latch_r <= PORT1_LATCH_RST;
    end else if (wr_p1) begin
      port1_latch_r <= req_i.wdata[PORT1_W-1:0];
    end
  end

  // port one direction
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port1_dir_r <= PORT1_DIR_RST;
    end else if (wr_d1) begin
      port1_dir_r <= req_i.wdata[PORT1_W-1:0];
    end
  end

  // port two output latch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port2_latch_r <= PORT2_LATCH_RST;
    end else if (wr_p2) begin
      port2_latch_r <= req_i.wdata[PORT2_W-1:0];
    end
  end

  // port three output latch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port3_latch_r <= PORT3_LATCH_RST;
    end else if (wr_p3) begin
      port3_latch_r <= req_i.wdata;
    end
  end

  // port three direction
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port3_dir_r <= PORT3_DIR_RST;
    end else if (wr_d3) begin
      port3_dir_r <= req_i.wdata;
    end
  end

  // port four output latch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port4_latch_r <= PORT4_LATCH_RST;
    end else if (wr_p4) begin
      port4_latch_r <= req_i.wdata;
    end
  end

  // port four direction
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port4_dir_r <= PORT4_DIR_RST;
    end else if (wr_d4) begin
      port4_dir_r <= req_i.wdata;
    end
  end

  // pin synchronisers, one per port; the first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port0_meta_r <= '0;
      port0_sync_r <= '0;
    end else begin
      port0_meta_r <= port0_pin_i;
      port0_sync_r <= port0_meta_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port1_meta_r <= '0;
      port1_sync_r <= '0;
    end else begin
      port1_meta_r <= port1_pin_i;
      port1_sync_r <= port1_meta_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port2_meta_r <= '0;
      port2_sync_r <= '0;
    end else begin
      port2_meta_r <= port2_pin_i;
      port2_sync_r <= port2_meta_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port3_meta_r <= '0;
      port3_sync_r <= '0;
    end else begin
      port3_meta_r <= port3_pin_i;
      port3_sync_r <= port3_meta_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port4_meta_r <= '0;
      port4_sync_r <= '0;
    end else begin
      port4_meta_r <= port4_pin_i;
      port4_sync_r <= port4_meta_r;
    end
  end

  // read mux: synchronised pins, two clocks behind the pad, taken in the request cycle, no input latch
  always_comb begin
    rdata_nxt = READ_IDLE;
    case (req_i.addr)
      PORT0_OUTPUT_LATCH_ADDR: begin
        rdata_nxt = port0_latch_r;
      end
      PORT0_PIN_INPUT_ADDR: begin
        rdata_nxt = port0_sync_r;
      end
      PORT1_OUTPUT_LATCH_ADDR: begin
        rdata_nxt = mixed_read({2'h0, port1_sync_r}, {2'h0, port1_latch_r}, {2'h0, port1_dir_r});
      end
      PORT1_DIRECTION_ADDR: begin
        rdata_nxt = {2'h0, port1_dir_r};
      end
      PORT2_OUTPUT_LATCH_ADDR: begin
        rdata_nxt = {5'h00, port2_latch_r};
      end
      PORT2_PIN_INPUT_ADDR: begin
        rdata_nxt = {5'h00, port2_sync_r};
      end
      PORT3_OUTPUT_LATCH_ADDR: begin
        rdata_nxt = mixed_read(port3_sync_r & port3_digital, port3_latch_r, port3_dir_r & port3_digital);
      end
      PORT3_DIRECTION_ADDR: begin
        rdata_nxt = port3_dir_r;
      end
      PORT4_OUTPUT_LATCH_ADDR: begin
        rdata_nxt = mixed_read(port4_sync_r, port4_latch_r, port4_dir_r);
      end
      PORT4_DIRECTION_ADDR: begin
        rdata_nxt = port4_dir_r;
      end
      default: begin
        rdata_nxt = READ_IDLE;
      end
    endcase
  end

  // read data register, captured in the cycle of the read strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= READ_IDLE;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= req_i.rd;
      if (req_i.rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // falling edge on port zero bit zero, gated by the interrupt pin select
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p00_prev_r <= 1'b0;
      ext_irq_zero_r <= 1'b0;
    end else begin
      p00_prev_r <= port0_sync_r[PORT_ZERO_BIT_ZERO];
      ext_irq_zero_r <= alt_i.interrupt_pin_select && p00_prev_r &&
                        !port0_sync_r[PORT_ZERO_BIT_ZERO];
    end
  end

  // falling edge on port two first pin; it reads back its own driven level, so output pulses count too
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p20_prev_r <= 1'b0;
      port_two_irq_r <= 1'b0;
    end else begin
      p20_prev_r <= port2_sync_r[PORT_TWO_FIRST_PIN];
      port_two_irq_r <= p20_prev_r && !port2_sync_r[PORT_TWO_FIRST_PIN];
    end
  end

  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign hit_o = (req_i.rd || req_i.wr) && (req_i.addr >= SFR_FIRST) && (req_i.addr <= SFR_LAST);

  // ports zero and two pull low on a zero latch and float on one; port two crystal pins float in dual-clock mode
  assign port0_pin_o = port0_latch_r;
  assign port0_pin_oe_o = ~port0_latch_r;
  assign port2_pin_o = port2_latch_r;
  assign port2_pin_oe_o = ~port2_latch_r & ~port2_crystal;

  assign port1_pin_o = port1_latch_r;
  assign port1_pin_oe_o = port1_dir_r;
  assign port3_pin_o = port3_latch_r;
  assign port3_pin_oe_o = port3_dir_r & port3_digital;
  assign port4_pin_o = port4_latch_r;
  assign port4_pin_oe_o = port4_dir_r;

  assign analog_pin_select_o = analog_sel;
  assign ext_irq_zero_set_o = ext_irq_zero_r;
  assign port_two_irq_set_o = port_two_irq_r;

endmodule

// ==== verif/pin_model.sv ====
`timescale 1ns/1ps
module pin_model #(parameter int W = 8) (
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] o_i,
  input wire logic [W-1:0] ext_i,
  output logic [W-1:0] pin_o
);
  // a driving port wins, otherwise the outside level is seen live, with no hold
  assign pin_o = (oe_i & o_i) | (~oe_i & ext_i);
endmodule

// ==== verif/five_port_parallel_io_chk.sv ====
`timescale 1ns/1ps
module five_port_parallel_io_chk
  import parallel_io_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire sfr_req_t req_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic rvalid_o,
  input wire alt_ctrl_t alt_i,
  input wire logic [PORT0_W-1:0] port0_pin_o,
  input wire logic [PORT0_W-1:0] port0_pin_oe_o,
  input wire logic [PORT1_W-1:0] port1_pin_o,
  input wire logic [PORT1_W-1:0] port1_pin_oe_o,
  input wire logic [PORT2_W-1:0] port2_pin_oe_o,
  input wire logic [PORT3_W-1:0] port3_pin_oe_o,
  input wire logic [PORT3_W-1:0] analog_pin_select_o,
  input wire logic ext_irq_zero_set_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic mapped;
  logic [7:0] wd_q;
  assign mapped = req_i.addr inside {6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h0A, 6'h0D, 6'h0E, 6'h0F};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_q <= 8'h00;
    end else begin
      wd_q <= req_i.wdata;
    end
  end
  a_read_valid_pulse: assert property (rvalid_o == $past(req_i.rd)) else $error("rvalid not one cycle after read");
  a_rdata_hold_idle: assert property (!$past(req_i.rd) |-> $stable(rdata_o)) else $error("rdata moved without read");
  a_unmapped_read_zero: assert property (req_i.rd && !mapped |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  a_p1_upper_zero: assert property (req_i.rd && req_i.addr inside {6'h01, 6'h0D} |=> rdata_o[7:6] == 2'h0)
    else $error("port1 upper bits not zero");
  a_p1_latch_write: assert property (req_i.wr && req_i.addr == 6'h01 |=> port1_pin_o == wd_q[5:0])
    else $error("port1 latch not written");
  a_p1_dir_write: assert property (req_i.wr && req_i.addr == 6'h0D |=> port1_pin_oe_o == wd_q[5:0])
    else $error("port1 direction not applied");
  a_p0_drive_low: assert property (port0_pin_oe_o == ~port0_pin_o) else $error("port0 drive not latch zero");
  a_xtal_pins_free: assert property (alt_i.dual_clock_mode |-> port2_pin_oe_o[2:1] == 2'h0)
    else $error("crystal pins driven");
  a_analog_sel_onehot: assert property (analog_pin_select_o == (alt_i.analog_input_disable ? 8'h00
    : 8'h01 << alt_i.analog_channel_select)) else $error("analog select wrong");
  a_analog_not_driven: assert property ((port3_pin_oe_o & analog_pin_select_o) == 8'h00)
    else $error("analog pin driven");
  a_irq_zero_gated: assert property (ext_irq_zero_set_o |-> $past(alt_i.interrupt_pin_select))
    else $error("ext irq while pin select off");
endmodule

bind five_port_parallel_io five_port_parallel_io_chk chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .alt_i(alt_i), .port0_pin_o(port0_pin_o), .port0_pin_oe_o(port0_pin_oe_o),
  .port1_pin_o(port1_pin_o), .port1_pin_oe_o(port1_pin_oe_o), .port2_pin_oe_o(port2_pin_oe_o),
  .port3_pin_oe_o(port3_pin_oe_o), .analog_pin_select_o(analog_pin_select_o), .ext_irq_zero_set_o(ext_irq_zero_set_o));

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import parallel_io_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  sfr_req_t req_i = '0;
  alt_ctrl_t alt_i = '{1'b0, 1'b0, 1'b1, 3'h0};
  logic [7:0] ext0 = 8'hFF, ext3 = 8'h00, ext4 = 8'h00, rdata_o, pin0, pin3, pin4, o0, e0, o3, e3, o4, e4, asel;
  logic [5:0] ext1 = 6'h00, pin1, o1, e1, m1, d1;
  logic [2:0] ext2 = 3'h7, pin2, o2, e2, m2;
  logic [7:0] m0, m3, d3, m4, d4;
  logic rvalid_o, hit_o, irq0, irq2;
  logic [31:0] rnd = 32'hC9E072F3;
  int fails = 0;
  int check_count = 0;
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  five_port_parallel_io dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .hit_o(hit_o), .alt_i(alt_i), .port0_pin_i(pin0), .port0_pin_o(o0), .port0_pin_oe_o(e0), .port1_pin_i(pin1),
    .port1_pin_o(o1), .port1_pin_oe_o(e1), .port2_pin_i(pin2), .port2_pin_o(o2), .port2_pin_oe_o(e2),
    .port3_pin_i(pin3), .port3_pin_o(o3), .port3_pin_oe_o(e3), .port4_pin_i(pin4), .port4_pin_o(o4),
    .port4_pin_oe_o(e4), .analog_pin_select_o(asel), .ext_irq_zero_set_o(irq0), .port_two_irq_set_o(irq2));
  pin_model #(.W(8)) pm0 (.oe_i(e0), .o_i(o0), .ext_i(ext0), .pin_o(pin0));
  pin_model #(.W(6)) pm1 (.oe_i(e1), .o_i(o1), .ext_i(ext1), .pin_o(pin1));
  pin_model #(.W(3)) pm2 (.oe_i(e2), .o_i(o2), .ext_i(ext2), .pin_o(pin2));
  pin_model #(.W(8)) pm3 (.oe_i(e3), .o_i(o3), .ext_i(ext3), .pin_o(pin3));
  pin_model #(.W(8)) pm4 (.oe_i(e4), .o_i(o4), .ext_i(ext4), .pin_o(pin4));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // reserved and unreadable locations are never touched by software
  function automatic logic rd_ok(input logic [5:0] a);
    return !(a inside {6'h05, 6'h06, 6'h07, 6'h09, 6'h0B, 6'h0C, 6'h15, 6'h21, 6'h23, 6'h24, 6'h25,
                       [6'h29:6'h35]});
  endfunction
  // writable port registers only: latches 00..04, directions 0D..0F
  function automatic logic [5:0] port_reg(input logic [2:0] i);
    return (i > 3'h4) ? {3'h1, i} : {3'h0, i};
  endfunction
  function automatic logic [7:0] an_sel();
    return alt_i.analog_input_disable ? 8'h00 : 8'h01 << alt_i.analog_channel_select;
  endfunction
  function automatic logic [2:0] oe2();
    return ~m2 & ~{alt_i.dual_clock_mode, alt_i.dual_clock_mode, 1'b0};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [5:0] a);
    case (a)
      6'h00: return m0;
      6'h01: return {2'h0, ext1 & ~d1 | m1 & d1};
      6'h02: return {5'h00, m2};
      6'h03: return (ext3 & ~d3 | m3 & d3) & ~an_sel();
      6'h04: return ext4 & ~d4 | m4 & d4;
      6'h08: return ext0 & m0;
      6'h0A: return {5'h00, ext2 & ~oe2()};
      6'h0D: return {2'h0, d1};
      6'h0E: return d3;
      6'h0F: return d4;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_i <= '{1'b0, 1'b1, a, d};
    @(posedge clk_i);
    req_i <= '0;
    case (a)
      6'h00: m0 = d;
      6'h01: m1 = d[5:0];
      6'h02: m2 = d[2:0];
      6'h03: m3 = d;
      6'h04: m4 = d;
      6'h0D: d1 = d[5:0];
      6'h0E: d3 = d;
      6'h0F: d4 = d;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk_i);
    req_i <= '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk_i);
    chk("hit", 8'h01, {7'h00, hit_o});
    @(posedge clk_i);
    req_i <= '0;
    @(negedge clk_i);
    chk("rvalid", 8'h01, {7'h00, rvalid_o});
    chk($sformatf("reg %h", a), exp_rd(a), rdata_o);
  endtask
  task automatic all_rd();
    for (int a = 0; a < 64; a++) begin
      if (rd_ok(a[5:0])) begin
        rd(a[5:0]);
      end
    end
    chk("p0 out", m0, o0);
    chk("p0 oe", ~m0, e0);
    chk("p2 out", {5'h00, m2}, {5'h00, o2});
    chk("p3 out", m3, o3);
    chk("analog sel", an_sel(), asel);
    chk("p1 out", {2'h0, m1}, {2'h0, o1});
    chk("p1 oe", {2'h0, d1}, {2'h0, e1});
    chk("p2 oe", {5'h00, oe2()}, {5'h00, e2});
    chk("p3 oe", d3 & ~an_sel(), e3);
    chk("p4 out", m4, o4);
    chk("p4 oe", d4, e4);
  endtask
  task automatic do_reset();
    rst_n_i <= 1'b0;
    alt_i <= '{1'b0, 1'b0, 1'b1, 3'h0};
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    {m0, m1, d1, m2, m3, d3, m4, d4} = {8'hFF, 12'h000, 3'h7, 32'h0};
    repeat (3) @(posedge clk_i);
    all_rd();
  endtask
  task automatic irq_try(input logic sel, input logic [7:0] e0x, input logic [7:0] e2x);
    logic [7:0] n0;
    logic [7:0] n2;
    n0 = 8'h00;
    n2 = 8'h00;
    @(posedge clk_i);
    alt_i.interrupt_pin_select <= sel;
    ext0 <= 8'hFF;
    repeat (4) @(posedge clk_i);
    ext0 <= 8'hFE;
    wr(6'h02, 8'h06);
    repeat (6) begin
      @(negedge clk_i);
      n0 = n0 + {7'h00, irq0};
      n2 = n2 + {7'h00, irq2};
    end
    chk("ext irq", e0x, n0);
    chk("p2 irq", e2x, n2);
    wr(6'h02, 8'h07);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    summarize();
  end
  initial begin
    do_reset();
    irq_try(1'b1, 8'h01, 8'h01);
    irq_try(1'b0, 8'h00, 8'h01);
    repeat (20) begin
      rnd = lfsr(rnd);
      @(posedge clk_i);
      ext0 <= rnd[7:0];
      ext3 <= rnd[15:8];
      ext4 <= rnd[23:16];
      ext1 <= rnd[29:24];
      ext2 <= rnd[31:29];
      rnd = lfsr(rnd);
      alt_i <= rnd[5:0];
      repeat (4) begin
        rnd = lfsr(rnd);
        wr(port_reg(rnd[2:0]), rnd[15:8]);
      end
      repeat (3) @(posedge clk_i);
      all_rd();
    end
    do_reset();
    summarize();
  end
endmodule
